// >>> logic/esi_pkg.sv
// package: register map, field positions and carrier types for error status and host interrupts
package esi_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 16;

	localparam logic [7:0] OFF_ERR2  = 8'h00;
	localparam logic [7:0] OFF_OPST  = 8'h04;
	localparam logic [7:0] OFF_ERR01 = 8'h08;
	localparam logic [7:0] OFF_WAKE  = 8'h0c;
	localparam logic [7:0] OFF_MODIF = 8'h10;
	localparam logic [7:0] OFF_ISTAT = 8'h14;
	localparam logic [7:0] OFF_IMASK = 8'h18;
	localparam logic [7:0] OFF_LEVEL = 8'h1c;

	localparam int unsigned B2_RETRY  = 1;
	localparam int unsigned B2_PARITY = 2;
	localparam int unsigned B2_DATA   = 3;
	localparam int unsigned B2_ID     = 4;
	localparam int unsigned B2_FAULT  = 5;
	localparam int unsigned B2_CYL    = 6;
	localparam int unsigned B2_SEEK   = 7;

	localparam int unsigned OPST_HARD = 6;
	localparam int unsigned OPST_ERR  = 7;
	localparam int unsigned MOD_NOINT = 0;

	localparam int unsigned IEV_OP   = 0;
	localparam int unsigned IEV_SEEK = 1;
	localparam int unsigned IEV_MED  = 2;
	localparam int unsigned IEV_W    = 3;

	localparam logic [7:0]  WAKE_CLEAR  = 8'h00;
	localparam logic [7:0]  ERR2_RST    = 8'h00;
	localparam logic [15:0] ERR01_RST   = 16'h0000;
	localparam logic [15:0] MODIF_RST   = 16'h0000;
	localparam logic [2:0]  IRQ_RST     = 3'h0;
	localparam int unsigned SYNC_STAGES = 3;

	typedef struct packed {
		logic retry_ok;
		logic parity;
		logic data_ecc;
		logic tape_hard;
		logic id_ecc;
		logic cyl_miss;
		logic overrun;
		logic seek_err;
		logic hard;
	} esi_err_ev_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} esi_reg_req_t;

	typedef enum logic {
		ST_IDLE,
		ST_BUSY
	} esi_op_st_t;
endpackage : esi_pkg

// >>> logic/esi_sync3.sv
// three-stage synchroniser for pin inputs, change accepted when last two stages agree
`timescale 1ns/100ps
module esi_sync3 #(
	parameter int unsigned W = 1
) (
	input  wire logic         i_clk,     // system clock
	input  wire logic         i_sys_rst, // async reset, active high
	input  wire logic [W-1:0] i_pin,     // asynchronous pin levels
	output logic      [W-1:0] o_level    // filtered level
);
	import esi_pkg::*;

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic [SYNC_STAGES-1:0] st_q;
			logic                   out_q;
			always_ff @(posedge i_clk or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					st_q <= '0;
				end else begin
					st_q <= {st_q[SYNC_STAGES-2:0], i_pin[g]};
				end
			end
			// first stage is read only by the second
			always_ff @(posedge i_clk or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					out_q <= 1'b0;
				end else if (st_q[1] == st_q[2]) begin
					out_q <= st_q[2];
				end
			end
			assign o_level[g] = out_q;
		end
	endgenerate
endmodule : esi_sync3

// >>> logic/esi_err2_fmt.sv
// next value of the third error-status byte from the accumulated byte and this cycle's events
`timescale 1ns/100ps
module esi_err2_fmt #(
	parameter bit TAPE_PARITY = 1'b1
) (
	input  wire logic               i_cur,   // operation in progress
	input  wire logic [7:0]         i_byte,  // current byte
	input  wire esi_pkg::esi_err_ev_t i_ev,  // event strobes of this cycle
	input  wire logic               i_tape,  // operation targets tape
	input  wire logic               i_fault, // selected unit hardware fault
	output logic      [7:0]         o_byte   // next byte
);
	import esi_pkg::*;

	logic [7:0] set_v;

	always_comb begin
		set_v            = 8'h00;
		set_v[B2_RETRY]  = i_tape & i_ev.retry_ok & i_cur;
		set_v[B2_PARITY] = i_tape & i_ev.parity & TAPE_PARITY & i_cur;
		set_v[B2_DATA]   = (i_tape ? i_ev.tape_hard : i_ev.data_ecc) & i_cur;
		set_v[B2_ID]     = ~i_tape & i_ev.id_ecc & i_cur;
		set_v[B2_FAULT]  = i_fault & i_cur;
		set_v[B2_CYL]    = (i_tape ? i_ev.overrun : i_ev.cyl_miss) & i_cur;
		set_v[B2_SEEK]   = ~i_tape & i_ev.seek_err & i_cur;
		// bit 0 carries no meaning and never sets
		o_byte           = (i_byte | set_v) & 8'hfe;
	end
endmodule : esi_err2_fmt

// >>> logic/esi_core.sv
// error status byte two, operation status summary and host interrupt request logic
// Functional notes
// - status byte two bit 0 always zero
// - tape retried-success sets bit 1, disk zero
// - tape parity sets bit 2 when module supports
// - disk data ECC sets bit 3, severity bit
// - tape hard data error sets bit 3
// - disk ID ECC sets bit 4, tape zero
// - unit hardware fault sets bit 5
// - disk wrong cylinder sets bit 6, recover
// - tape over/under-run sets bit 6, informational
// - disk seek error bit 7, recalibrate unless inhibited
// - drive one of eight request lines
// - modifier bit 0 suppresses operation-complete interrupt
// - seek and medium interrupts never masked on request lines, mask register gates o_irq
// - request-line interrupt cleared by reset or zero to wake-up
// - line chosen by strapped level zero to seven
// - operation status bit 7 summarises error bytes
// - operation status bit 6 reports hard severity
`timescale 1ns/100ps
module esi_core #(
	parameter bit TAPE_PARITY = 1'b1
) (
	input  wire logic                 i_clk,          // system clock, 200 MHz
	input  wire logic                 i_sys_rst,      // async reset, active high
	input  wire esi_pkg::esi_reg_req_t i_reg,         // register port request
	output logic      [15:0]          o_reg_rdata,    // read data, cycle after read
	input  wire logic                 i_op_start,     // operation begins, pulse
	input  wire logic                 i_op_done,      // operation complete, pulse
	input  wire logic                 i_op_tape,      // operation is a tape function
	input  wire logic [15:0]          i_err01,        // error bytes 0 and 1 at completion
	input  wire esi_pkg::esi_err_ev_t i_err_ev,       // error strobes while busy
	input  wire logic                 i_retry_inhibit, // retries disabled for this operation
	input  wire logic                 i_seek_done,    // seek complete event, pulse
	input  wire logic                 i_medium_chg,   // medium change event, pulse
	input  wire logic                 i_unit_fault,   // fault pin of selected unit
	input  wire logic [2:0]           i_level_strap,  // strapped interrupt level pins
	output logic                      o_recal_req,    // recalibrate then re-seek, pulse
	output logic      [7:0]           o_int_req,      // bus interrupt request lines, high = assert
	output logic                      o_irq           // local level interrupt
);
	import esi_pkg::*;

	esi_op_st_t     st_q;
	logic [7:0]     err2_q;
	logic [7:0]     err2_d;
	logic [15:0]    err01_q;
	logic           tape_q;
	logic           hard_q;
	logic [15:0]    modif_q;
	logic [IEV_W-1:0] istat_q;
	logic [IEV_W-1:0] imask_q;
	logic           int_q;
	logic           recal_q;
	logic [15:0]    rdata_q;
	logic           fault_s;
	logic [2:0]     level_s;
	logic [7:0]     opst;
	logic           busy;
	logic           op_irq;
	logic           clr_cmd;
	logic [IEV_W-1:0] iev;
	logic [IEV_W-1:0] w1c;

	esi_sync3 #(.W(4)) u_sync (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_pin     ({i_unit_fault, i_level_strap}),
		.o_level   ({fault_s, level_s})
	);

	esi_err2_fmt #(.TAPE_PARITY(TAPE_PARITY)) u_fmt (
		.i_cur   (busy),
		.i_byte  (err2_q),
		.i_ev    (i_err_ev),
		.i_tape  (tape_q),
		.i_fault (fault_s),
		.o_byte  (err2_d)
	);

	assign busy = (st_q == ST_BUSY);

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_q <= ST_IDLE;
		end else begin
			case (st_q)
				ST_IDLE: if (i_op_start) st_q <= ST_BUSY;
				ST_BUSY: if (i_op_done) st_q <= ST_IDLE;
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// byte two accumulates only during the operation, so it reflects the last one
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			err2_q <= ERR2_RST;
			tape_q <= 1'b0;
			hard_q <= 1'b0;
		end else if (i_op_start && !busy) begin
			err2_q <= ERR2_RST;
			tape_q <= i_op_tape;
			hard_q <= 1'b0;
		end else if (busy) begin
			err2_q <= err2_d;
			hard_q <= hard_q | i_err_ev.hard;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			err01_q <= ERR01_RST;
		end else if (busy && i_op_done) begin
			err01_q <= i_err01;
		end
	end

	// wrong track or cylinder: ask for track-zero seek and re-seek
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			recal_q <= 1'b0;
		end else begin
			recal_q <= busy & ~tape_q & ~i_retry_inhibit & (i_err_ev.seek_err | i_err_ev.cyl_miss);
		end
	end
	assign o_recal_req = recal_q;

	always_comb begin
		opst            = 8'h00;
		opst[OPST_ERR]  = |{err01_q, err2_q};
		// severity also qualifies the ECC bits of byte two
		opst[OPST_HARD] = hard_q & (|err01_q | err2_q[B2_DATA] | err2_q[B2_ID]);
	end

	assign clr_cmd = i_reg.wr && (i_reg.addr == OFF_WAKE) && (i_reg.wdata[7:0] == WAKE_CLEAR);
	assign op_irq  = busy & i_op_done & ~modif_q[MOD_NOINT];

	// set wins over the clear command in the same cycle
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			int_q <= 1'b0;
		end else if (op_irq || i_seek_done || i_medium_chg) begin
			int_q <= 1'b1;
		end else if (clr_cmd) begin
			int_q <= 1'b0;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_line
			assign o_int_req[g] = int_q & (level_s == 3'(g));
		end
	endgenerate

	assign iev = {i_medium_chg, i_seek_done, op_irq};
	assign w1c = (i_reg.wr && i_reg.addr == OFF_ISTAT) ? i_reg.wdata[IEV_W-1:0] : '0;

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			istat_q <= IRQ_RST;
		end else begin
			istat_q <= (istat_q & ~w1c) | iev;
		end
	end
	assign o_irq = |(istat_q & imask_q);

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			modif_q <= MODIF_RST;
			imask_q <= IRQ_RST;
		end else if (i_reg.wr) begin
			if (i_reg.addr == OFF_MODIF) modif_q <= i_reg.wdata;
			if (i_reg.addr == OFF_IMASK) imask_q <= i_reg.wdata[IEV_W-1:0];
		end
	end

	// unmapped reads return zero
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rdata_q <= 16'h0000;
		end else if (i_reg.rd) begin
			case (i_reg.addr)
				OFF_ERR2:  rdata_q <= {8'h00, err2_q};
				OFF_OPST:  rdata_q <= {8'h00, opst};
				OFF_ERR01: rdata_q <= err01_q;
				OFF_WAKE:  rdata_q <= {15'h0000, int_q};
				OFF_MODIF: rdata_q <= modif_q;
				OFF_ISTAT: rdata_q <= {13'h0000, istat_q};
				OFF_IMASK: rdata_q <= {13'h0000, imask_q};
				OFF_LEVEL: rdata_q <= {13'h0000, level_s};
				default:   rdata_q <= 16'h0000;
			endcase
		end else begin
			rdata_q <= 16'h0000;
		end
	end
	assign o_reg_rdata = rdata_q;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_irq_event;
		op_irq || i_seek_done || i_medium_chg;
	endsequence

	sequence s_quiet_clear;
		clr_cmd && !(op_irq || i_seek_done || i_medium_chg);
	endsequence

	sequence s_op_begin;
		i_op_start && !busy;
	endsequence

	sequence s_op_end;
		busy && i_op_done;
	endsequence

	a_bit0_zero: assert property (err2_q[0] == 1'b0)
		else $error("byte two bit 0 set");
	a_disk_no_retry: assert property (!tape_q |-> !err2_q[B2_RETRY])
		else $error("retry bit set on disk");
	a_retry_sets: assert property (busy && tape_q && i_err_ev.retry_ok |=> err2_q[B2_RETRY])
		else $error("tape retry not recorded");
	a_parity_gate: assert property ((!tape_q || !TAPE_PARITY) |-> !err2_q[B2_PARITY])
		else $error("parity bit set without tape parity");
	a_data_ecc: assert property (busy && !tape_q && i_err_ev.data_ecc |=> err2_q[B2_DATA])
		else $error("data ecc not recorded");
	a_tape_hard: assert property (busy && tape_q && !i_err_ev.tape_hard && !err2_q[B2_DATA] |=> !err2_q[B2_DATA])
		else $error("tape data bit set without hard error");
	a_tape_no_id: assert property (tape_q |-> !err2_q[B2_ID])
		else $error("id ecc bit set on tape");
	a_fault_sets: assert property (busy && fault_s |=> err2_q[B2_FAULT])
		else $error("fault not recorded");
	a_cyl_overrun: assert property (busy && tape_q && i_err_ev.overrun |=> err2_q[B2_CYL])
		else $error("overrun not recorded");
	a_recal_req: assert property (busy && !tape_q && !i_retry_inhibit && i_err_ev.seek_err |=> o_recal_req)
		else $error("no recalibrate after seek error");
	a_tape_no_seek: assert property (tape_q |-> !err2_q[B2_SEEK] && !o_recal_req)
		else $error("seek error reported on tape");
	a_op_masked: assert property (busy && i_op_done && modif_q[MOD_NOINT] && !i_seek_done && !i_medium_chg
		&& !int_q |=> !int_q)
		else $error("masked completion raised interrupt");
	a_seek_irq: assert property (i_seek_done || i_medium_chg |=> int_q ##0 $onehot(o_int_req))
		else $error("seek or medium interrupt missing");
	a_irq_raise: assert property (s_irq_event |=> int_q [*1] ##0 o_int_req[level_s])
		else $error("wrong interrupt line");
	a_int_hold: assert property (int_q && !clr_cmd |=> int_q)
		else $error("interrupt dropped without clear");
	a_clear_int: assert property (s_quiet_clear |=> !int_q ##0 o_int_req == 8'h00)
		else $error("clear command ignored");
	a_summary: assert property ($rose(err2_q[B2_FAULT]) |-> opst[OPST_ERR])
		else $error("summary bit missing");
	a_hard_sev: assert property (|err01_q && hard_q |-> opst[OPST_HARD])
		else $error("severity bit missing");
	// done may follow start at once, so busy is only checked on the first cycle
	a_start_clears: assert property (i_op_start && !busy |=> busy && err2_q == ERR2_RST)
		else $error("byte two not cleared at start");

	// each event lands on its own bit, and only for its medium
	a_parity_sets: assert property (busy && tape_q && i_err_ev.parity && TAPE_PARITY |=> err2_q[B2_PARITY])
		else $error("parity error not recorded");
	a_tape_hard_sets: assert property (busy && tape_q && i_err_ev.tape_hard |=> err2_q[B2_DATA])
		else $error("tape hard error not recorded");
	a_disk_data_only: assert property (busy && !tape_q && !i_err_ev.data_ecc && !err2_q[B2_DATA] |=> !err2_q[B2_DATA])
		else $error("data bit set on disk without ecc error");
	a_id_ecc_sets: assert property (busy && !tape_q && i_err_ev.id_ecc |=> err2_q[B2_ID])
		else $error("id ecc not recorded");
	a_cyl_sets: assert property (busy && !tape_q && i_err_ev.cyl_miss |=> err2_q[B2_CYL])
		else $error("cylinder miscompare not recorded");
	a_cyl_recal: assert property (busy && !tape_q && !i_retry_inhibit && i_err_ev.cyl_miss |=> o_recal_req)
		else $error("no recalibrate after cylinder miscompare");
	a_tape_no_cyl: assert property (busy && tape_q && !i_err_ev.overrun && !err2_q[B2_CYL] |=> !err2_q[B2_CYL])
		else $error("cylinder bit set on tape without overrun");
	a_disk_no_overrun: assert property (busy && !tape_q && !i_err_ev.cyl_miss && !err2_q[B2_CYL] |=> !err2_q[B2_CYL])
		else $error("overrun reported on disk");
	a_seek_sets: assert property (busy && !tape_q && i_err_ev.seek_err |=> err2_q[B2_SEEK])
		else $error("seek error not recorded");
	a_recal_only: assert property (busy && i_retry_inhibit |=> !o_recal_req)
		else $error("recalibrate while retries inhibited");
	a_idle_hold: assert property (!busy && !i_op_start |=> $stable(err2_q))
		else $error("byte two changed while idle");
	a_byte_sticky: assert property (busy |=> (err2_q & $past(err2_q)) == $past(err2_q))
		else $error("byte two bit lost during operation");
	a_start_tape: assert property (s_op_begin |=> tape_q == $past(i_op_tape))
		else $error("medium not latched at start");
	a_start_hard: assert property (s_op_begin |=> !hard_q)
		else $error("severity not cleared at start");

	// operation status summary and severity
	a_done_latch: assert property (s_op_end |=> !busy && err01_q == $past(i_err01))
		else $error("error bytes not latched at completion");
	a_summary_err01: assert property (|err01_q |-> opst[OPST_ERR])
		else $error("summary bit missing for bytes zero and one");
	a_summary_byte2: assert property (|err2_q |-> opst[OPST_ERR])
		else $error("summary bit missing for byte two");
	a_soft_sev: assert property (!hard_q |-> !opst[OPST_HARD])
		else $error("hard severity without hard error");
	a_sev_ecc: assert property (hard_q && (err2_q[B2_DATA] || err2_q[B2_ID]) |-> opst[OPST_HARD])
		else $error("ecc severity missing");

	// interrupt request lines and status
	a_op_irq_raise: assert property (s_op_end ##0 !modif_q[MOD_NOINT] |=> int_q && istat_q[IEV_OP])
		else $error("completion interrupt missing");
	a_op_masked_stat: assert property (s_op_end ##0 modif_q[MOD_NOINT] && !istat_q[IEV_OP] |=> !istat_q[IEV_OP])
		else $error("masked completion set status");
	a_med_irq: assert property (i_medium_chg |=> int_q && istat_q[IEV_MED])
		else $error("medium change interrupt missing");
	a_seek_stat: assert property (i_seek_done |=> istat_q[IEV_SEEK])
		else $error("seek complete status missing");
	a_one_line: assert property ($onehot0(o_int_req))
		else $error("more than one request line driven");
	a_line_strap: assert property (int_q |-> o_int_req == (8'h01 << level_s))
		else $error("request line differs from strap");
	a_no_req_idle: assert property (!int_q |-> o_int_req == 8'h00)
		else $error("request line without interrupt");
	a_no_false_set: assert property (!int_q && !(op_irq || i_seek_done || i_medium_chg) |=> !int_q)
		else $error("interrupt raised without event");
	a_w1c_clear: assert property (iev == '0 && w1c == '1 |=> istat_q == '0)
		else $error("status not cleared by write one");

	// register port answers
	a_rdata_idle: assert property (!i_reg.rd |=> o_reg_rdata == 16'h0000)
		else $error("read data outside read cycle");
	a_wake_read: assert property (i_reg.rd && i_reg.addr == OFF_WAKE |=> o_reg_rdata == {15'h0000, $past(int_q)})
		else $error("wake-up read wrong");
	a_level_read: assert property (i_reg.rd && i_reg.addr == OFF_LEVEL |=> o_reg_rdata == {13'h0000, $past(level_s)})
		else $error("level read wrong");
	a_err2_read: assert property (i_reg.rd && i_reg.addr == OFF_ERR2 |=> o_reg_rdata[0] == 1'b0 && o_reg_rdata[15:8] == 8'h00)
		else $error("byte two read wrong");
endmodule : esi_core

// >>> test/esi_host_model.sv
// host processor model: register port master and interrupt clear
`timescale 1ns/100ps
module esi_host_model
	import esi_pkg::*;
(
	input  wire logic            i_clk,   // system clock
	input  wire logic [15:0]     i_rdata, // read data from device
	output esi_pkg::esi_reg_req_t o_reg   // register request
);
	initial o_reg = '0;

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk);
		o_reg <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_clk);
		o_reg <= '0;
	endtask : wr

	// data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge i_clk);
		o_reg <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge i_clk);
		o_reg <= '0;
		@(negedge i_clk);
		d = i_rdata;
	endtask : rd

	task automatic clr_int();
		wr(OFF_WAKE, {8'h00, WAKE_CLEAR});
	endtask : clr_int

	task automatic set_mod(input logic m);
		wr(OFF_MODIF, {15'h0000, m});
	endtask : set_mod
endmodule : esi_host_model

// >>> test/test_error_status_and_host_interrupts.sv
// self-checking bench for error status and host interrupt logic
`timescale 1ns/100ps
module test_error_status_and_host_interrupts;
	import esi_pkg::*;
	logic         i_clk;
	logic         i_sys_rst;
	esi_reg_req_t req;
	logic [15:0]  rdata;
	logic         op_start;
	logic         op_done;
	logic         op_tape;
	logic [15:0]  err01;
	esi_err_ev_t  err_ev;
	logic         inh;
	logic         seek_done;
	logic         med_chg;
	logic         fault;
	logic [2:0]   strap;
	logic         recal;
	logic [7:0]   int_req;
	logic         irq;
	int           miscompares = 0;
	int           n_checks = 0;
	int           n_recal = 0;
	int           cyc = 0;
	int           saved;

	esi_core #(.TAPE_PARITY(1'b1)) i_dut (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg(req), .o_reg_rdata(rdata),
		.i_op_start(op_start), .i_op_done(op_done), .i_op_tape(op_tape), .i_err01(err01),
		.i_err_ev(err_ev), .i_retry_inhibit(inh), .i_seek_done(seek_done), .i_medium_chg(med_chg),
		.i_unit_fault(fault), .i_level_strap(strap), .o_recal_req(recal), .o_int_req(int_req),
		.o_irq(irq));
	esi_host_model i_host (.i_clk(i_clk), .i_rdata(rdata), .o_reg(req));

	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		n_recal += int'(recal);
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			conclude();
		end
	end

	task automatic conclude();
		if (miscompares == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] d;
		i_host.rd(a, d);
		chk(d, exp);
	endtask : rchk

	task automatic ichk(input logic [7:0] exp);
		@(posedge i_clk);
		@(negedge i_clk);
		chk({8'h00, int_req}, {8'h00, exp});
	endtask : ichk

	// fault pin needs several cycles through its synchroniser before done
	task automatic op(input logic t, input esi_err_ev_t e, input logic [15:0] e01, input logic ri);
		@(posedge i_clk);
		op_start <= 1'b1;
		op_tape <= t;
		@(posedge i_clk);
		op_start <= 1'b0;
		err_ev <= e;
		inh <= ri;
		@(posedge i_clk);
		err_ev <= '0;
		repeat (6) @(posedge i_clk);
		err01 <= e01;
		op_done <= 1'b1;
		@(posedge i_clk);
		op_done <= 1'b0;
		repeat (2) @(posedge i_clk);
	endtask : op

	task automatic pulse_ev(input logic med);
		@(posedge i_clk);
		seek_done <= ~med;
		med_chg <= med;
		@(posedge i_clk);
		seek_done <= 1'b0;
		med_chg <= 1'b0;
		repeat (2) @(posedge i_clk);
	endtask : pulse_ev

	initial begin
		{op_start, op_done, op_tape, inh, seek_done, med_chg, fault} = '0;
		err01 = '0;
		err_ev = '0;
		strap = 3'h5;
		i_sys_rst = 1'b1;
		repeat (3) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		repeat (6) @(posedge i_clk);
		ichk(8'h00);
		rchk(OFF_ERR2, 16'h0000);
		rchk(OFF_LEVEL, 16'h0005);
		rchk(8'h40, 16'h0000);
		op(1'b0, '{data_ecc: 1'b1, hard: 1'b1, default: 1'b0}, 16'h0000, 1'b0);
		rchk(OFF_ERR2, 16'h0008);
		rchk(OFF_OPST, 16'h00c0);
		ichk(8'h20);
		rchk(OFF_WAKE, 16'h0001);
		repeat (20) @(posedge i_clk);
		ichk(8'h20);
		i_host.clr_int();
		ichk(8'h00);
		op(1'b0, '{data_ecc: 1'b0, hard: 1'b0, default: 1'b1}, 16'h0000, 1'b0);
		rchk(OFF_ERR2, 16'h00d0);
		rchk(OFF_OPST, 16'h0080);
		chk(16'(n_recal != 0), 16'h0001);
		saved = n_recal;
		op(1'b0, '{seek_err: 1'b1, default: 1'b0}, 16'h0000, 1'b1);
		chk(16'(n_recal), 16'(saved));
		fault <= 1'b1;
		op(1'b1, '{default: 1'b1}, 16'h0001, 1'b0);
		fault <= 1'b0;
		rchk(OFF_ERR2, 16'h006e);
		rchk(OFF_ERR01, 16'h0001);
		rchk(OFF_OPST, 16'h00c0);
		repeat (8) @(posedge i_clk);
		op(1'b0, '0, 16'h0000, 1'b0);
		rchk(OFF_ERR2, 16'h0000);
		rchk(OFF_OPST, 16'h0000);
		i_host.clr_int();
		i_host.set_mod(1'b1);
		rchk(OFF_MODIF, 16'h0001);
		op(1'b0, '0, 16'h0000, 1'b0);
		ichk(8'h00);
		i_host.wr(OFF_ISTAT, 16'h0007);
		i_host.wr(OFF_IMASK, 16'h0002);
		pulse_ev(1'b0);
		ichk(8'h20);
		chk({15'h0000, irq}, 16'h0001);
		i_host.wr(OFF_ISTAT, 16'h0002);
		ichk(8'h20);
		chk({15'h0000, irq}, 16'h0000);
		i_host.clr_int();
		ichk(8'h00);
		pulse_ev(1'b1);
		ichk(8'h20);
		chk({15'h0000, irq}, 16'h0000);
		rchk(OFF_ISTAT, 16'h0004);
		@(posedge i_clk);
		i_sys_rst <= 1'b1;
		@(posedge i_clk);
		i_sys_rst <= 1'b0;
		ichk(8'h00);
		rchk(OFF_ISTAT, 16'h0000);
		rchk(OFF_MODIF, 16'h0000);
		conclude();
	end
endmodule : test_error_status_and_host_interrupts
